// *** design/burst_sram_port.sv ***
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Read address taken on input clock rise, write address on complement rise.
// [RULE_02] Each accepted address moves a burst of four consecutive words.
// [RULE_03] Word width is a build option of 8, 9, 18 or 36 bits.
// [RULE_04] Address, selects and write data are registered by the input clock pair.
// [RULE_05] Read data launches from output clock pair, or input pair in single-clock mode.
// [RULE_06] One word moves on every rising edge of true and complement clocks.
// [RULE_07] Read and write bursts proceed independently and concurrently.
// [RULE_08] Only rising edges of each clock signal are used, never falling edges.
// [RULE_09] Separate active-low select for the read port and the write port.
// [RULE_10] Array writes complete internally without any write pulse from the controller.
// [RULE_11] Reads return newest data, including writes still pending inside the device.
// [RULE_12] Echo strobe pair is driven aligned with each read data word.
// [RULE_13] Controller keeps the input clock at or below 300 MHz.
// [RULE_14] Controller asserts each select only on its own address edge.
// [RULE_15] Controller presents four write words on consecutive input clock rises.
module burst_sram_port #(
	parameter int DATA_W = 36, // RULE_03
	parameter int ADDR_W = 8
) (
	input  wire logic                       ref_clk,              // 250 MHz core clock
	input  wire logic                       sys_rst,              // Synchronous, active high
	input  wire burst_sram_pkg::link_clk_t  link_clk,             // Input and output clock pairs
	input  wire logic                       single_clk_mode,      // Output launch on input pair
	input  wire logic                       read_port_select_n,   // Read select, active low
	input  wire logic                       write_port_select_n,  // Write select, active low
	input  wire logic [ADDR_W-1:0]          addr,                 // Shared address bus
	input  wire logic [DATA_W-1:0]          wdata,                // Write data port
	output logic      [DATA_W-1:0]          rdata,                // Read data port
	output logic                            rdata_valid,          // Read word on rdata
	output logic      [1:0]                 returned_strobe_pair, // Echo strobes, true/comp
	output logic                            write_ready           // Write buffer has room
);
	import burst_sram_pkg::*;

	localparam int SYNC_W = 7 + ADDR_W + DATA_W;
	localparam int DEPTH  = 1 << ADDR_W;
	localparam logic [SYNC_W-1:0] SYNC_RST = {4'hF, 3'h3, {(ADDR_W + DATA_W){1'b0}}};

	typedef logic [DATA_W-1:0] word_t;
	typedef word_t [BURST_LEN-1:0] burst_t;

	// Every pin crosses into ref_clk; clocks and data share the same delay so they stay aligned
	logic [SYNC_W-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
	logic [3:0]        clk_prev_q, clk_prev_d;
	link_clk_t         clk_s;
	logic              mode_s, rps_n_s, wps_n_s;
	logic [ADDR_W-1:0] addr_s;
	word_t             wdata_s;
	logic              k_rise, kn_rise, oc_rise, ocn_rise, in_edge, out_edge;

	wr_state_t         wst_q, wst_d;
	logic [ADDR_W-1:0] wadr_q, wadr_d;
	burst_t            wwords_q, wwords_d;
	logic [3:0]        wmask_q, wmask_d;
	logic [1:0]        widx_q, widx_d;

	logic [ADDR_W-1:0] fadr_q [FIFO_DEPTH];
	logic [ADDR_W-1:0] fadr_d [FIFO_DEPTH];
	burst_t            fdat_q [FIFO_DEPTH];
	burst_t            fdat_d [FIFO_DEPTH];
	logic              wptr_q, wptr_d, rptr_q, rptr_d;
	logic [1:0]        cnt_q, cnt_d;
	logic              push, drain;

	logic              rpend_q, rpend_d, ract_q, ract_d;
	logic [ADDR_W-1:0] rpadr_q, rpadr_d, radr_q, radr_d;
	logic [1:0]        ridx_q, ridx_d;
	word_t             rdata_q, rdata_d;
	logic              rvalid_q, rvalid_d;
	logic [1:0]        strobe_q, strobe_d;

	burst_t            mem [DEPTH];

	// Newest copy wins: assembly register, then buffer newest first, then the array
	function automatic word_t pick(input logic [ADDR_W-1:0] a, input logic [1:0] i);
		word_t w;
		w = mem[a][i];
		if (cnt_q == CNT_FULL && fadr_q[wptr_q] == a) begin
			w = fdat_q[wptr_q][i];
		end
		if (cnt_q != 2'h0 && fadr_q[~wptr_q] == a) begin
			w = fdat_q[~wptr_q][i];
		end
		if (wst_q != W_IDLE && wadr_q == a && wmask_q[i]) begin
			w = wwords_q[i];
		end
		return w;
	endfunction

	always_comb begin
		sync1_d    = {link_clk, single_clk_mode, read_port_select_n, write_port_select_n,
			addr, wdata}; // RULE_04
		sync2_d    = sync1_q;
		{clk_s, mode_s, rps_n_s, wps_n_s, addr_s, wdata_s} = sync2_q;
		clk_prev_d = clk_s;
		// Rising edge of each signal on its own; the complement is never a falling true edge
		k_rise   = clk_s.k & ~clk_prev_q[3];   // RULE_08
		kn_rise  = clk_s.k_n & ~clk_prev_q[2]; // RULE_08
		oc_rise  = mode_s ? k_rise : (clk_s.c & ~clk_prev_q[1]);    // RULE_05
		ocn_rise = mode_s ? kn_rise : (clk_s.c_n & ~clk_prev_q[0]); // RULE_05
		in_edge  = k_rise | kn_rise;
		out_edge = oc_rise | ocn_rise;
	end

	// Write path: address on complement rise, four words on the following input edges
	always_comb begin
		wst_d    = wst_q;
		wadr_d   = wadr_q;
		wwords_d = wwords_q;
		wmask_d  = wmask_q;
		widx_d   = widx_q;
		push     = 1'b0;
		case (wst_q)
			W_IDLE: begin
				if (kn_rise && !wps_n_s) begin // RULE_01 RULE_09
					wadr_d  = addr_s;
					wmask_d = 4'h0;
					widx_d  = 2'h0;
					wst_d   = W_COLLECT;
				end
			end
			W_COLLECT: begin
				if (in_edge) begin // RULE_06
					wwords_d[widx_q] = wdata_s;
					wmask_d[widx_q]  = 1'b1;
					widx_d           = widx_q + 2'h1;
					if (widx_q == IDX_LAST) begin // RULE_02
						wst_d = W_HOLD;
					end
				end
			end
			W_HOLD: begin
				// A full buffer parks the burst here and new write addresses are ignored
				if (cnt_q != CNT_FULL) begin
					push  = 1'b1;
					wst_d = W_IDLE;
				end
			end
			default: wst_d = W_IDLE;
		endcase
	end

	// Self-timed array writes drain the buffer; a read launch owns the array that cycle
	always_comb begin
		fadr_d = fadr_q;
		fdat_d = fdat_q;
		wptr_d = wptr_q;
		rptr_d = rptr_q;
		drain  = (cnt_q != 2'h0) && !out_edge; // RULE_10
		if (push) begin
			fadr_d[wptr_q] = wadr_q;
			fdat_d[wptr_q] = wwords_q;
			wptr_d         = ~wptr_q;
		end
		if (drain) begin
			rptr_d = ~rptr_q;
		end
		cnt_d = cnt_q + {1'b0, push} - {1'b0, drain};
	end

	// Read path runs beside the write path; it reads write-path state only through pick
	always_comb begin
		rpend_d  = rpend_q;
		rpadr_d  = rpadr_q;
		ract_d   = ract_q;
		radr_d   = radr_q;
		ridx_d   = ridx_q;
		rdata_d  = rdata_q;
		rvalid_d = rvalid_q;
		strobe_d = strobe_q;
		if (out_edge) begin
			rvalid_d = 1'b0;
			strobe_d = oc_rise ? STROBE_TRUE : STROBE_COMP; // RULE_12
		end
		if (ract_q && out_edge) begin // RULE_06
			rdata_d  = pick(radr_q, ridx_q); // RULE_11
			rvalid_d = 1'b1;
			ridx_d   = ridx_q + 2'h1;
			ract_d   = (ridx_q != IDX_LAST); // RULE_02
		end else if (rpend_q && oc_rise) begin // RULE_05
			rdata_d  = pick(rpadr_q, 2'h0); // RULE_11
			rvalid_d = 1'b1;
			radr_d   = rpadr_q;
			ridx_d   = 2'h1;
			ract_d   = 1'b1;
			rpend_d  = 1'b0;
		end
		if (k_rise && !rps_n_s && !rpend_d) begin // RULE_01 RULE_07 RULE_09
			rpend_d = 1'b1;
			rpadr_d = addr_s;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			sync1_q    <= SYNC_RST; // Idle-high clocks: no false rise at release
			sync2_q    <= SYNC_RST;
			clk_prev_q <= '1;
			wst_q      <= W_IDLE;
			wadr_q     <= '0;
			wwords_q   <= '0;
			wmask_q    <= '0;
			widx_q     <= '0;
			fadr_q     <= '{default: '0};
			fdat_q     <= '{default: '0};
			wptr_q     <= 1'b0;
			rptr_q     <= 1'b0;
			cnt_q      <= '0;
			rpend_q    <= 1'b0;
			rpadr_q    <= '0;
			ract_q     <= 1'b0;
			radr_q     <= '0;
			ridx_q     <= '0;
			rdata_q    <= '0;
			rvalid_q   <= 1'b0;
			strobe_q   <= STROBE_RST;
		end else begin
			sync1_q    <= sync1_d;
			sync2_q    <= sync2_d;
			clk_prev_q <= clk_prev_d;
			wst_q      <= wst_d;
			wadr_q     <= wadr_d;
			wwords_q   <= wwords_d;
			wmask_q    <= wmask_d;
			widx_q     <= widx_d;
			fadr_q     <= fadr_d;
			fdat_q     <= fdat_d;
			wptr_q     <= wptr_d;
			rptr_q     <= rptr_d;
			cnt_q      <= cnt_d;
			rpend_q    <= rpend_d;
			rpadr_q    <= rpadr_d;
			ract_q     <= ract_d;
			radr_q     <= radr_d;
			ridx_q     <= ridx_d;
			rdata_q    <= rdata_d;
			rvalid_q   <= rvalid_d;
			strobe_q   <= strobe_d;
		end
	end

	// Array has no reset; contents are undefined until written, as in the real part
	always_ff @(posedge ref_clk) begin
		if (!sys_rst && drain) begin
			mem[fadr_q[rptr_q]] <= fdat_q[rptr_q]; // RULE_10
		end
	end

	assign rdata                = rdata_q;
	assign rdata_valid          = rvalid_q;
	assign returned_strobe_pair = strobe_q;
	assign write_ready          = (cnt_q != CNT_FULL);

	// Checks
	word_t hold_word;
	assign hold_word = wwords_q[ridx_q];

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (sys_rst);

	chk_width_legal: assert property ( // RULE_03
		DATA_W == 8 || DATA_W == 9 || DATA_W == 18 || DATA_W == 36)
		else $error("word width not 8, 9, 18 or 36");
	chk_rd_addr_take: assert property ( // RULE_01
		k_rise && !rps_n_s && !rpend_q && !oc_rise |=> rpend_q && rpadr_q == $past(addr_s))
		else $error("read address not taken on input clock rise");
	chk_wr_addr_take: assert property ( // RULE_09
		kn_rise && !wps_n_s && wst_q == W_IDLE |=> wst_q == W_COLLECT && wadr_q == $past(addr_s))
		else $error("write address not taken on complement rise");
	chk_burst_four: assert property ( // RULE_02
		wst_q == W_COLLECT && in_edge && widx_q == IDX_LAST |=> wst_q == W_HOLD && wmask_q == 4'hF)
		else $error("write burst did not close after four words");
	chk_word_launch: assert property ( // RULE_06
		ract_q && out_edge |=> rdata_valid ##0 $changed(ridx_q))
		else $error("active read burst missed an output edge");
	chk_quiet_launch: assert property ( // RULE_08
		!out_edge |=> $stable(rdata) && $stable(returned_strobe_pair))
		else $error("read data moved without an output clock rise");
	chk_strobe_align: assert property ( // RULE_12
		oc_rise |=> returned_strobe_pair == STROBE_TRUE)
		else $error("echo strobe not aligned with output clock");
	chk_self_write: assert property ( // RULE_10
		wst_q == W_HOLD && cnt_q != CNT_FULL |=> wst_q == W_IDLE && cnt_q != 2'h0)
		else $error("completed burst not handed to array writer");
	chk_coherent: assert property ( // RULE_11
		out_edge && ract_q && wst_q != W_IDLE && wadr_q == radr_q && wmask_q[ridx_q]
		|=> rdata == $past(hold_word))
		else $error("read missed data of a pending write");
	chk_concurrent: assert property ( // RULE_07
		k_rise && !rps_n_s && !rpend_q && !oc_rise && wst_q != W_IDLE |=> rpend_q)
		else $error("read refused while write busy");

	cov_read_burst:  cover property (ract_q && ridx_q == IDX_LAST && out_edge);
	cov_full_buffer: cover property (cnt_q == CNT_FULL && wst_q == W_HOLD);
	cov_bypass_read: cover property (out_edge && ract_q && wst_q != W_IDLE && wadr_q == radr_q);

endmodule

// *** design/burst_sram_pkg.sv ***
package burst_sram_pkg;

	localparam int          BURST_LEN    = 4;
	localparam int          IDX_W        = 2;
	localparam int          FIFO_DEPTH   = 2;
	localparam int          LINK_MAX_MHZ = 300;
	localparam logic [1:0]  STROBE_RST   = 2'h0;
	localparam logic [1:0]  STROBE_TRUE  = 2'h1;
	localparam logic [1:0]  STROBE_COMP  = 2'h2;
	localparam logic [1:0]  IDX_LAST     = 2'h3;
	localparam logic [1:0]  CNT_FULL     = 2'h2;

	typedef struct packed {
		logic k;
		logic k_n;
		logic c;
		logic c_n;
	} link_clk_t;

	typedef enum logic [1:0] {
		W_IDLE    = 2'b00,
		W_COLLECT = 2'b01,
		W_HOLD    = 2'b11
	} wr_state_t;

endpackage

// *** sim/mem_ctrl_model.sv ***
`timescale 1ns/1ps
module mem_ctrl_model #(
	parameter int DW = 18,
	parameter int AW = 4
) (
	output burst_sram_pkg::link_clk_t link_clk,            // Input and output clock pairs
	output logic                      read_port_select_n,  // Read select, active low
	output logic                      write_port_select_n, // Write select, active low
	output logic [AW-1:0]             addr,                // Shared address
	output logic [DW-1:0]             wdata,               // Write words
	input  wire logic                 write_ready          // Device can take a burst
);
	import burst_sram_pkg::*;
	typedef struct {
		bit            wr;
		logic [AW-1:0] a;
		logic [DW-1:0] w [BURST_LEN];
	} op_t;
	op_t        ops_q [$];
	op_t        cur;
	int         wn   = -1;
	int         rgap = 0;
	// Phases of {k,k_n,c,c_n}; high phase shorter than low, so no fall meets a rise
	logic [3:0] pat [8] = '{4'h9, 4'h8, 4'hA, 4'h2, 4'h6, 4'h4, 4'h5, 4'h1};
	real        dt [8]  = '{17.5, 12.5, 20.0, 12.5, 17.5, 12.5, 20.0, 12.5};

	task automatic push(input bit wr, input logic [AW-1:0] a, input logic [DW-1:0] w [BURST_LEN]);
		op_t o;
		o.wr = wr;
		o.a = a;
		o.w = w;
		ops_q.push_back(o);
	endtask

	// 8 MHz link, far below the fastest allowed input clock
	initial begin
		link_clk = '0;
		#20.25; // Quarter offset keeps link edges off the core clock's edges
		forever foreach (pat[i]) begin
			link_clk = pat[i];
			#(dt[i]);
		end
	end

	initial begin
		read_port_select_n = 1'b1;
		write_port_select_n = 1'b1;
		addr = '0;
		wdata = '0;
		forever begin
			@(posedge link_clk.k_n);
			#55;
			write_port_select_n = 1'b1;
			wdata = (wn >= 0) ? cur.w[wn] : ~wdata;
			if (rgap > 0)
				rgap--;
			// A read may follow a write to its address at once: each word lands before launch
			if (ops_q.size() > 0 && !ops_q[0].wr && rgap == 0) begin
				addr = ops_q[0].a;
				read_port_select_n = 1'b0;
				rgap = 2;
				void'(ops_q.pop_front());
			end else
				addr = ~addr;
			@(posedge link_clk.k);
			#55;
			read_port_select_n = 1'b1;
			wdata = (wn >= 0) ? cur.w[wn+1] : ~wdata;
			// One idle period after the last word: its closing edge still belongs to that burst
			if (wn >= 0)
				wn = (wn == 2) ? -2 : wn + 2;
			else
				wn = -1;
			if (ops_q.size() > 0 && ops_q[0].wr && wn == -1 && write_ready) begin
				cur = ops_q.pop_front();
				addr = cur.a;
				write_port_select_n = 1'b0;
				wn = 0;
			end else
				addr = ~addr;
		end
	end
endmodule

// *** sim/quad_rate_burst_sram_port_test.sv ***
`timescale 1ns/1ps
`define CHECK(got, exp) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
	$display("Error at %0t: got %h expected %h", $time, got, exp); end end
module quad_rate_burst_sram_port_test;
	import burst_sram_pkg::*;
	localparam int DW = 18;
	localparam int AW = 4;
	logic          ref_clk;
	logic          sys_rst;
	logic          single_clk_mode;
	link_clk_t     link_clk;
	logic          rsel_n;
	logic          wsel_n;
	logic [AW-1:0] addr;
	logic [DW-1:0] wdata;
	logic [DW-1:0] rdata;
	logic          rdata_valid;
	logic [1:0]    strobe;
	logic [1:0]    strobe_prev;
	logic          write_ready;
	logic [DW-1:0] exp_w;
	logic [DW-1:0] mem [2**AW][BURST_LEN];
	logic [DW-1:0] exp_q [$];
	int            miscompares = 0;
	int            n_compared  = 0;
	int            widx        = 0;
	bit            hung        = 1'b0;

	initial begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	burst_sram_port #(.DATA_W(DW), .ADDR_W(AW)) u_burst_sram_port (
		.ref_clk(ref_clk), .sys_rst(sys_rst), .link_clk(link_clk),
		.single_clk_mode(single_clk_mode), .read_port_select_n(rsel_n),
		.write_port_select_n(wsel_n), .addr(addr), .wdata(wdata), .rdata(rdata),
		.rdata_valid(rdata_valid), .returned_strobe_pair(strobe), .write_ready(write_ready));

	mem_ctrl_model #(.DW(DW), .AW(AW)) u_mem_ctrl_model (
		.link_clk(link_clk), .read_port_select_n(rsel_n), .write_port_select_n(wsel_n),
		.addr(addr), .wdata(wdata), .write_ready(write_ready));

	task automatic complete_run();
		$display("Compared %0d, miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Expected words are fixed in program order; the model keeps that order
	task automatic op(input bit wr, input int a);
		logic [DW-1:0] w [BURST_LEN];
		foreach (w[i]) begin
			w[i] = DW'($urandom);
			if (wr)
				mem[a][i] = w[i];
			else
				exp_q.push_back(mem[a][i]);
		end
		u_mem_ctrl_model.push(wr, AW'(a), w);
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		while ((u_mem_ctrl_model.ops_q.size() != 0 || exp_q.size() != 0) && n < 20000) begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 20000) begin
			miscompares++;
			hung = 1'b1;
		end else begin
			repeat (200) @(posedge ref_clk);
		end
	endtask

	always @(posedge ref_clk) begin
		strobe_prev <= strobe;
		if (!sys_rst && rdata_valid && strobe !== strobe_prev) begin
			`CHECK(exp_q.size() != 0, 1'b1)
			if (exp_q.size() != 0) begin
				exp_w = exp_q.pop_front();
				`CHECK(rdata, exp_w)
			end
			`CHECK(strobe, widx[0] ? STROBE_COMP : STROBE_TRUE)
			widx <= widx + 1;
		end
	end

	initial begin
		void'($urandom(35));
		sys_rst = 1'b1;
		single_clk_mode = 1'b0;
		repeat (12) @(posedge ref_clk);
		`CHECK({rdata, rdata_valid, strobe, write_ready}, {{DW{1'b0}}, 1'b0, STROBE_RST, 1'b1})
		#1 sys_rst = 1'b0;
		// Same-address read follows each write within two link periods, so it reads the partly collected burst
		for (int a = 0; a < 2**AW; a++) begin
			op(1'b1, a);
			op(1'b0, a);
			if (a > 0)
				op(1'b0, a - 1);
		end
		wait_idle();
		if (!hung) begin
			@(posedge ref_clk);
			#1 single_clk_mode = 1'b1;
			repeat (20) @(posedge ref_clk);
			repeat (16) op(($urandom % 3) == 0, $urandom % (2**AW));
			wait_idle();
		end
		complete_run();
	end
endmodule
